// *** pkg/lufr_defs.svh ***
// register indices, field positions, reset values and timing counts
`ifndef LUFR_DEFS_SVH
`define LUFR_DEFS_SVH
// ===========================================================
// register indices (byte address is four times the index)
`define LUFR_IDX_IEN 8'ha4
`define LUFR_IDX_FLAG 8'ha5
`define LUFR_IDX_DATA 8'ha6
`define LUFR_IDX_LIN 8'ha7
`define LUFR_IDX_FRST 8'ha8
`define LUFR_IDX_BAUD 8'ha9
`define LUFR_IDX_STAT 8'haa
// ===========================================================
// flag and enable bit positions
`define LUFR_B_RFO 4
`define LUFR_B_RFU 3
`define LUFR_B_TFO 2
`define LUFR_B_FRAMING_ERROR_FLAG 1
`define LUFR_B_TI 0
`define LUFR_NFLAG 5
// ===========================================================
// lin control bit positions
`define LUFR_B_LIN_ENABLE 7
`define LUFR_B_MASTER 6
`define LUFR_B_BRK 3
`define LUFR_B_BLEN_HI 2
// fifo reset bits
`define LUFR_B_RXRST 0
`define LUFR_B_TXRST 1
// ===========================================================
// reset values and timing
`define LUFR_DATA_RST 8'h00
`define LUFR_BRK_BASE 5'd13
`define LUFR_CLK_HZ 50000000
`define LUFR_BIT_RATE 19200
`define LUFR_BAUD_RST 16'(`LUFR_CLK_HZ / `LUFR_BIT_RATE)
`endif

// *** pkg/lufr_pkg.sv ***
// types shared by the serial port design files
package lufr_pkg;
  // ===========================================================
  // transmit sequencer states, gray along idle-start-data-stop
  typedef enum logic [2:0] {
    LUFR_TX_IDLE = 3'b000,
    LUFR_TX_START = 3'b001,
    LUFR_TX_DATA = 3'b011,
    LUFR_TX_STOP = 3'b010,
    LUFR_TX_BRK = 3'b110,
    LUFR_TX_DELIM = 3'b111
  } lufr_tx_e;
  // receive sequencer states
  typedef enum logic [1:0] {
    LUFR_RX_IDLE = 2'b00,
    LUFR_RX_START = 2'b01,
    LUFR_RX_DATA = 2'b11,
    LUFR_RX_STOP = 2'b10
  } lufr_rx_e;
  typedef logic [7:0] lufr_byte_t;
endpackage : lufr_pkg

// *** verilog/lufr_fifo.sv ***
// flip-flop fifo used for both receive and transmit queues
`timescale 1ns/1ns
module lufr_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic clr,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic full,
  output logic empty
);
  import lufr_pkg::*;
  localparam int AW = $clog2(DEPTH);
  // ===========================================================
  // elaboration check
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate
  logic [W-1:0] mem_r [DEPTH]; // storage
  logic [AW-1:0] wp_r, wp_nxt; // write index
  logic [AW-1:0] rp_r, rp_nxt; // read index
  logic [AW:0] cnt_r, cnt_nxt; // fill level
  logic do_push, do_pop;
  // pushes to a full queue and pops from an empty one are dropped
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign full = cnt_r == (AW+1)'(DEPTH);
  assign empty = cnt_r == '0;
  assign dout = mem_r[rp_r];
  // ===========================================================
  // pointer next state
  always_comb begin
    wp_nxt = wp_r + AW'(do_push);
    rp_nxt = rp_r + AW'(do_pop);
    cnt_nxt = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    if (clr) begin // reset action empties the queue
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  // storage needs no reset; content is only read once counted
  always_ff @(posedge pclk) begin
    if (ce && do_push && !clr) begin
      mem_r[wp_r] <= din;
    end
  end
endmodule : lufr_fifo

// *** verilog/lufr_rx.sv ***
// receive shifter: start detect, mid-bit sampling, stop check
`timescale 1ns/1ns
`include "lufr_defs.svh"
module lufr_rx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic rxd,
  input wire logic [15:0] baud,
  output lufr_pkg::lufr_byte_t rx_byte,
  output logic rx_valid,
  output logic rx_framing_error_flag
);
  import lufr_pkg::*;
  lufr_rx_e st_r, st_nxt; // sequencer
  logic [15:0] cnt_r, cnt_nxt; // clocks within a bit
  logic [2:0] bit_r, bit_nxt; // data bit index
  lufr_byte_t sh_r, sh_nxt; // shift register
  logic vld_r, vld_nxt, fe_r, fe_nxt;
  logic tick;
  assign tick = cnt_r == baud - 16'd1;
  assign rx_byte = sh_r;
  assign rx_valid = vld_r;
  assign rx_framing_error_flag = fe_r;
  // ===========================================================
  // sequencer next state
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = tick ? 16'd0 : cnt_r + 16'd1;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    vld_nxt = 1'b0;
    fe_nxt = fe_r;
    unique case (st_r)
      LUFR_RX_IDLE: begin // wait for falling start edge
        cnt_nxt = 16'd0;
        if (!rxd) begin
          st_nxt = LUFR_RX_START;
        end
      end
      LUFR_RX_START: begin // check at half bit, reject glitches
        if (cnt_r == (baud >> 1)) begin
          cnt_nxt = 16'd0;
          bit_nxt = 3'd0;
          st_nxt = rxd ? LUFR_RX_IDLE : LUFR_RX_DATA;
        end
      end
      LUFR_RX_DATA: begin // lsb first
        if (tick) begin
          sh_nxt = {rxd, sh_r[7:1]};
          bit_nxt = bit_r + 3'd1;
          if (bit_r == 3'd7) begin
            st_nxt = LUFR_RX_STOP;
          end
        end
      end
      LUFR_RX_STOP: begin // a low stop bit is a framing error
        if (tick) begin
          vld_nxt = 1'b1;
          fe_nxt = ~rxd;
          st_nxt = LUFR_RX_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= LUFR_RX_IDLE;
      cnt_r <= 16'd0;
      bit_r <= 3'd0;
      sh_r <= `LUFR_DATA_RST;
      vld_r <= 1'b0;
      fe_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      vld_r <= vld_nxt;
      fe_r <= fe_nxt;
    end
  end
endmodule : lufr_rx

// *** verilog/lufr_top.sv ***
// serial port with lin break, fifo flags and apb register access
//
// Contract
// - rx overflow sets flag; one enables interrupt
// - zero write or rx fifo reset clears
// - bad stop bit sets framing flag
// - tx complete when all sent, fifo empty
// - data buffer read pops oldest rx byte
// - data buffer write pushes into tx fifo
// - plain serial function unchanged under lin
// - frame order break, sync, id, data, checksum
// - no gaps; frame time equals bit count
// - break is 13+extra dominant, one recessive
// - break request sticky, self clears, lin cancels
`timescale 1ns/1ns
`include "lufr_defs.svh"
module lufr_top #(
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  output logic irq
);
  import lufr_pkg::*;
  // ===========================================================
  // address decode
  function automatic logic hit(input logic [11:0] a,
                               input logic [7:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction : hit
  // ===========================================================
  // pin synchroniser
  logic rxd_s1_r, rxd_s2_r; // two stages before any logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
    end else if (ce) begin
      rxd_s1_r <= rxd;
      rxd_s2_r <= rxd_s1_r;
    end
  end
  // ===========================================================
  // declarations
  logic [31:0] prdata_r, prdata_nxt; // read data held for access
  logic pready_r, pready_nxt; // answer in the access phase
  logic perr_r, perr_nxt; // unmapped address
  logic under_r, under_nxt; // rx fifo was empty at setup
  logic [`LUFR_NFLAG-1:0] flag_r, flag_nxt; // sticky events
  logic [`LUFR_NFLAG-1:0] ien_r, ien_nxt; // interrupt enables
  logic [`LUFR_NFLAG-1:0] ev; // one-cycle events
  logic irq_r, irq_nxt;
  logic lin_en_r, lin_en_nxt; // lin enable
  logic master_r, master_nxt; // master select
  logic brk_r, brk_nxt; // break request / in progress
  logic [2:0] blen_r, blen_nxt; // break length extra
  logic [15:0] baud_r, baud_nxt; // clocks per bit
  lufr_tx_e tx_st_r, tx_st_nxt; // transmit sequencer
  logic [15:0] tcnt_r, tcnt_nxt; // clocks within a bit
  logic [4:0] tbit_r, tbit_nxt; // bit index in byte or break
  lufr_byte_t tsh_r, tsh_nxt; // transmit shifter
  logic txd_r, txd_nxt;
  logic setup, acc, wr_acc, rd_acc, mapped, ttick, brk_done;
  logic rx_push, rx_pop, rx_full, rx_empty, rx_clr;
  logic tx_push, tx_pop, tx_full, tx_empty, tx_clr;
  lufr_byte_t rx_head, tx_head, rx_byte;
  logic rx_valid, rx_framing_error_flag;
  assign setup = psel & ~penable;
  assign acc = psel & penable & pready_r;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign mapped = hit(paddr, `LUFR_IDX_IEN) | hit(paddr, `LUFR_IDX_FLAG)
    | hit(paddr, `LUFR_IDX_DATA) | hit(paddr, `LUFR_IDX_LIN)
    | hit(paddr, `LUFR_IDX_FRST) | hit(paddr, `LUFR_IDX_BAUD)
    | hit(paddr, `LUFR_IDX_STAT);
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = perr_r;
  assign txd = txd_r;
  assign irq = irq_r;
  // ===========================================================
  // fifos and receiver
  // the data buffer has no storage of its own: it is the fifo ends
  assign rx_push = rx_valid & ~rx_full;
  assign rx_pop = rd_acc & hit(paddr, `LUFR_IDX_DATA) & ~under_r;
  assign tx_push = wr_acc & hit(paddr, `LUFR_IDX_DATA) & ~tx_full;
  assign rx_clr = wr_acc & hit(paddr, `LUFR_IDX_FRST)
    & pwdata[`LUFR_B_RXRST];
  assign tx_clr = wr_acc & hit(paddr, `LUFR_IDX_FRST)
    & pwdata[`LUFR_B_TXRST];
  lufr_fifo #(.W(8), .DEPTH(DEPTH)) u_rxq (
    .pclk(pclk), .presetn(presetn), .ce(ce), .clr(rx_clr),
    .push(rx_push), .din(rx_byte), .pop(rx_pop), .dout(rx_head),
    .full(rx_full), .empty(rx_empty)
  );
  lufr_fifo #(.W(8), .DEPTH(DEPTH)) u_txq (
    .pclk(pclk), .presetn(presetn), .ce(ce), .clr(tx_clr),
    .push(tx_push), .din(pwdata[7:0]), .pop(tx_pop), .dout(tx_head),
    .full(tx_full), .empty(tx_empty)
  );
  // receive path runs the same whether lin is on or off
  lufr_rx u_rx (
    .pclk(pclk), .presetn(presetn), .ce(ce), .rxd(rxd_s2_r),
    .baud(baud_r), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_framing_error_flag(rx_framing_error_flag)
  );
  // ===========================================================
  // apb slave: answer prepared in setup, done in first access cycle
  always_comb begin
    pready_nxt = setup;
    perr_nxt = setup ? ~mapped : perr_r;
    under_nxt = setup ? rx_empty : under_r;
    prdata_nxt = prdata_r;
    // unmapped writes answer with zero data as well as the error
    if (setup && (!pwrite || !mapped)) begin
      prdata_nxt = 32'h0000_0000;
      if (hit(paddr, `LUFR_IDX_IEN)) begin
        prdata_nxt[`LUFR_NFLAG-1:0] = ien_r;
      end else if (hit(paddr, `LUFR_IDX_FLAG)) begin
        prdata_nxt[`LUFR_NFLAG-1:0] = flag_r;
      end else if (hit(paddr, `LUFR_IDX_DATA)) begin
        prdata_nxt[7:0] = rx_empty ? `LUFR_DATA_RST : rx_head;
      end else if (hit(paddr, `LUFR_IDX_LIN)) begin
        prdata_nxt[7:0] = {lin_en_r, master_r, 2'b00, brk_r, blen_r};
      end else if (hit(paddr, `LUFR_IDX_BAUD)) begin
        prdata_nxt[15:0] = baud_r;
      end else if (hit(paddr, `LUFR_IDX_STAT)) begin
        prdata_nxt[4:0] = {tx_st_r != LUFR_TX_IDLE, tx_full, tx_empty,
                           rx_full, rx_empty};
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      perr_r <= 1'b0;
      under_r <= 1'b0;
    end else if (ce) begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      perr_r <= perr_nxt;
      under_r <= under_nxt;
    end
  end
  // ===========================================================
  // event flags, enables and interrupt
  always_comb begin
    ev = '0;
    ev[`LUFR_B_RFO] = rx_valid & rx_full;
    ev[`LUFR_B_RFU] = rd_acc & hit(paddr, `LUFR_IDX_DATA) & under_r;
    ev[`LUFR_B_TFO] = wr_acc & hit(paddr, `LUFR_IDX_DATA) & tx_full;
    ev[`LUFR_B_FRAMING_ERROR_FLAG] = rx_valid & rx_framing_error_flag;
    ev[`LUFR_B_TI] = 1'b0;
    if (tx_st_r == LUFR_TX_STOP && ttick && tx_empty) begin
      ev[`LUFR_B_TI] = 1'b1;
    end
    flag_nxt = flag_r;
    ien_nxt = ien_r;
    if (wr_acc && hit(paddr, `LUFR_IDX_FLAG)) begin
      // one enables; zero clears the flag and disables it
      ien_nxt = pwdata[`LUFR_NFLAG-1:0];
      flag_nxt = flag_r & pwdata[`LUFR_NFLAG-1:0];
    end else if (wr_acc && hit(paddr, `LUFR_IDX_IEN)) begin
      ien_nxt = pwdata[`LUFR_NFLAG-1:0];
    end
    if (rx_clr) begin
      flag_nxt[`LUFR_B_RFO] = 1'b0;
    end
    // an event in the clearing cycle is kept
    flag_nxt = flag_nxt | ev;
    irq_nxt = |(flag_r & ien_r);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= '0;
      ien_r <= '0;
      irq_r <= 1'b0;
    end else if (ce) begin
      flag_r <= flag_nxt;
      ien_r <= ien_nxt;
      irq_r <= irq_nxt;
    end
  end
  // ===========================================================
  // lin control and bit rate
  always_comb begin
    lin_en_nxt = lin_en_r;
    master_nxt = master_r;
    brk_nxt = brk_r;
    blen_nxt = blen_r;
    baud_nxt = baud_r;
    if (wr_acc && hit(paddr, `LUFR_IDX_LIN)) begin
      lin_en_nxt = pwdata[`LUFR_B_LIN_ENABLE];
      // mode may only change while lin is off
      if (!lin_en_r) begin
        master_nxt = pwdata[`LUFR_B_MASTER];
      end
      blen_nxt = pwdata[`LUFR_B_BLEN_HI:0];
      // writing zero to the break bit keeps a pending break; clearing lin enable drops it
      if (pwdata[`LUFR_B_BRK] && pwdata[`LUFR_B_LIN_ENABLE] && master_nxt) begin
        brk_nxt = 1'b1;
      end
    end
    if (brk_done || !lin_en_nxt) begin
      brk_nxt = 1'b0;
    end
    if (wr_acc && hit(paddr, `LUFR_IDX_BAUD)) begin
      baud_nxt = (pwdata[15:0] < 16'd2) ? 16'd2 : pwdata[15:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lin_en_r <= 1'b0;
      master_r <= 1'b0;
      brk_r <= 1'b0;
      blen_r <= 3'b000;
      baud_r <= `LUFR_BAUD_RST;
    end else if (ce) begin
      lin_en_r <= lin_en_nxt;
      master_r <= master_nxt;
      brk_r <= brk_nxt;
      blen_r <= blen_nxt;
      baud_r <= baud_nxt;
    end
  end
  // ===========================================================
  // transmit sequencer: break, then queued bytes back to back
  assign ttick = tcnt_r == baud_r - 16'd1;
  always_comb begin
    tx_st_nxt = tx_st_r;
    tcnt_nxt = ttick ? 16'd0 : tcnt_r + 16'd1;
    tbit_nxt = tbit_r;
    tsh_nxt = tsh_r;
    txd_nxt = txd_r;
    tx_pop = 1'b0;
    brk_done = 1'b0;
    unique case (tx_st_r)
      LUFR_TX_IDLE: begin
        tcnt_nxt = 16'd0;
        txd_nxt = 1'b1;
        // a pending break goes before any queued byte
        if (brk_r && lin_en_r && master_r) begin
          tx_st_nxt = LUFR_TX_BRK;
          tbit_nxt = 5'd0;
          txd_nxt = 1'b0;
        end else if (!tx_empty) begin
          tx_pop = 1'b1;
          tsh_nxt = tx_head;
          tx_st_nxt = LUFR_TX_START;
          txd_nxt = 1'b0;
        end
      end
      LUFR_TX_START: begin
        if (ttick) begin
          tx_st_nxt = LUFR_TX_DATA;
          tbit_nxt = 5'd0;
          txd_nxt = tsh_r[0];
        end
      end
      LUFR_TX_DATA: begin // lsb first
        if (ttick) begin
          if (tbit_r == 5'd7) begin
            tx_st_nxt = LUFR_TX_STOP;
            txd_nxt = 1'b1;
          end else begin
            tsh_nxt = tsh_r >> 1;
            txd_nxt = tsh_r[1];
            tbit_nxt = tbit_r + 5'd1;
          end
        end
      end
      LUFR_TX_STOP: begin
        if (ttick) begin
          // next byte starts at once so frame time is fixed
          if (!tx_empty) begin
            tx_pop = 1'b1;
            tsh_nxt = tx_head;
            tx_st_nxt = LUFR_TX_START;
            txd_nxt = 1'b0;
          end else begin
            tx_st_nxt = LUFR_TX_IDLE;
          end
        end
      end
      LUFR_TX_BRK: begin // 13 plus extra dominant bits
        if (ttick) begin
          if (tbit_r == `LUFR_BRK_BASE + {2'b00, blen_r} - 5'd1) begin
            tx_st_nxt = LUFR_TX_DELIM;
            txd_nxt = 1'b1;
          end else begin
            tbit_nxt = tbit_r + 5'd1;
          end
        end
      end
      LUFR_TX_DELIM: begin // one recessive delimiter bit
        if (ttick) begin
          brk_done = 1'b1;
          // queued header follows at once; an idle cycle would stretch
          // the delimiter beyond one bit
          if (!tx_empty && lin_en_r) begin
            tx_pop = 1'b1;
            tsh_nxt = tx_head;
            tx_st_nxt = LUFR_TX_START;
            txd_nxt = 1'b0;
          end else begin
            tx_st_nxt = LUFR_TX_IDLE;
          end
        end
      end
      default: begin // illegal code: back to a quiet line
        tx_st_nxt = LUFR_TX_IDLE;
        txd_nxt = 1'b1;
      end
    endcase
    // dropping lin enable aborts a break in flight
    if (!lin_en_r && (tx_st_r == LUFR_TX_BRK ||
                      tx_st_r == LUFR_TX_DELIM)) begin
      tx_st_nxt = LUFR_TX_IDLE;
      txd_nxt = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r <= LUFR_TX_IDLE;
      tcnt_r <= 16'd0;
      tbit_r <= 5'd0;
      tsh_r <= `LUFR_DATA_RST;
      txd_r <= 1'b1;
    end else if (ce) begin
      tx_st_r <= tx_st_nxt;
      tcnt_r <= tcnt_nxt;
      tbit_r <= tbit_nxt;
      tsh_r <= tsh_nxt;
      txd_r <= txd_nxt;
    end
  end
endmodule : lufr_top

// *** tb/lufr_top_asserts.sv ***
// concurrent checks on the serial port's bus and interrupt pins
`timescale 1ns/1ns
module lufr_top_asserts #(
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic txd,
  input wire logic irq
);
  // ===========================================================
  // helpers
  logic acc; // transfer completes at this edge
  logic mapped; // one of the seven words
  assign acc = psel && penable && pready;
  assign mapped = paddr inside {12'h290, 12'h294, 12'h298, 12'h29c,
    12'h2a0, 12'h2a4, 12'h2a8};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ===========================================================
  // properties
  property p_rdy_acc;
    pready |-> psel && penable;
  endproperty
  a_rdy_acc: assert property (p_rdy_acc)
    else $error("pready outside access");
  property p_rdy_next;
    psel && !penable && ce |=> pready;
  endproperty
  a_rdy_next: assert property (p_rdy_next)
    else $error("wait state seen");
  property p_err_zero;
    pready && pslverr |-> prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error with data");
  property p_map_ok;
    pready && mapped |-> !pslverr;
  endproperty
  a_map_ok: assert property (p_map_ok)
    else $error("mapped word refused");
  property p_hi_zero;
    pready && !pwrite |-> prdata[31:16] == 16'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("upper bits set");
  property p_flag_clr;
    acc && pwrite && paddr == 12'h294 && pwdata[4:0] == 5'h00
      |-> ##[1:2] !irq;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("irq after clear");
  property p_mask;
    acc && pwrite && paddr == 12'h290 && pwdata[4:0] == 5'h00
      |-> ##[1:2] !irq;
  endproperty
  a_mask: assert property (p_mask)
    else $error("irq while masked");
  property p_rd_stable;
    pready && !pwrite ##1 !psel |-> $stable(prdata);
  endproperty
  a_rd_stable: assert property (p_rd_stable)
    else $error("read data moved");
  // main scenarios reached
  c_brk: cover property (acc && pwrite && paddr == 12'h29c && pwdata[3]);
  c_irq: cover property ($rose(irq));
  c_err: cover property (acc && pslverr);
endmodule : lufr_top_asserts
bind lufr_top lufr_top_asserts #(.DEPTH(DEPTH)) lufr_top_asserts_i (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
  .txd(txd), .irq(irq));

// *** tb/lufr_lin_node.sv ***
// lin bus node: wired-and single wire and a byte sender
`timescale 1ns/1ns
module lufr_lin_node (
  input wire logic pclk,
  input wire logic txd,
  output logic rxd
);
  logic drv_r = 1'b1; // own driver, recessive at rest
  // dominant low wins; the pull-up gives recessive when all release
  assign rxd = txd & drv_r;
  // start, eight bits lsb first, stop level picked by the caller
  task automatic send_byte(input logic [7:0] b, input logic stop,
    input int baud);
    logic [9:0] fr;
    fr = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drv_r <= fr[i];
      repeat (baud) @(posedge pclk);
    end
    drv_r <= 1'b1;
  endtask : send_byte
endmodule : lufr_lin_node

// *** tb/tb_top.sv ***
// self-checking bench for the serial port with lin break
`timescale 1ns/1ns
module tb_top;
  // ===========================================================
  // signals and notes
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, rxd, txd, irq;
  logic [32:0] exp_q [$], msk_q [$], me, mm;
  int brk_q [$];
  int err_count = 0;
  int n_checks = 0;
  int run = 0;
  logic lvl = 1'b1;
  logic hold = 1'b0;
  lufr_pkg::lufr_byte_t sent [20];
  lufr_pkg::lufr_byte_t b;
  int seed_v;
  localparam int BAUD = 4; // short bit time keeps the run brief
  localparam logic [32:0] ALL = {1'b1, 32'hffffffff};
  lufr_top #(.DEPTH(16)) lufr_top_i (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
  lufr_lin_node lufr_lin_node_i (.pclk(pclk), .txd(txd), .rxd(rxd));
  initial begin
    forever #10 pclk = ~pclk;
  end
  // ===========================================================
  // reporting
  task automatic chk(input string w, input logic [32:0] e,
    input logic [32:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic give_up(input string w);
    chk(w, 33'h1, 33'h0);
    final_report();
  endtask : give_up
  // ===========================================================
  // apb master; a read leaves its expectation for the monitor
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [32:0] e, input logic [32:0] m);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin // pready and data taken at the rising edge itself
      @(posedge pclk);
      n++;
      if (n > 50) give_up("pready wait");
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0);
  endtask : wr
  task automatic rdx(input logic [11:0] a, input logic [32:0] e,
    input logic [32:0] m);
    apb(1'b0, a, 32'h0, e, m);
  endtask : rdx
  task automatic poll(input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] want);
    int n;
    n = 0;
    do begin
      rdx(a, 33'h0, 33'h0);
      n++;
      if (n > 3000) give_up("poll");
    end while ((rd & m) !== want);
  endtask : poll
  task automatic irq_is(input logic e);
    repeat (3) @(negedge pclk); // irq lags the flags by a cycle
    chk("irq", {32'h0, e}, {32'h0, irq});
  endtask : irq_is
  // ===========================================================
  // monitors: read results and long low runs on txd
  always @(negedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size()) begin
      me = exp_q.pop_front();
      mm = msk_q.pop_front();
      if (mm != 33'h0) chk("read", me & mm, {pslverr, prdata} & mm);
    end
    if (txd === lvl) begin
      run++;
    end else begin
      if (!lvl && run > 10 * BAUD && brk_q.size()) begin
        chk("break low", 33'(brk_q.pop_front()), 33'(run));
        hold = 1'b1;
      end else if (lvl && hold) begin // delimiter, then sync start
        hold = 1'b0;
        chk("delimiter", 33'(brk_q.pop_front()), 33'(run));
      end
      lvl = txd;
      run = 1;
    end
  end
  // ===========================================================
  // main sequence
  initial begin
    seed_v = $urandom(66);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdx(12'h2a4, {1'b0, 32'h0a2c}, ALL); // baud reset
    rdx(12'h2a8, {1'b0, 32'h05}, ALL); // both fifos empty
    rdx(12'h298, 33'h0, ALL); // empty read gives zero
    rdx(12'h2b0, {1'b1, 32'h0}, ALL); // unmapped word refused
    wr(12'h2a4, 32'(BAUD));
    wr(12'h290, 32'h1f);
    for (int i = 0; i < 20; i++) begin // overfill, echo overfills rx
      sent[i] = 8'($urandom);
      wr(12'h298, {24'h0, sent[i]});
    end
    poll(12'h2a8, 32'h14, 32'h04);
    repeat (4 * BAUD) @(posedge pclk);
    rdx(12'h294, {1'b0, 32'h1d}, ALL);
    irq_is(1'b1);
    for (int i = 0; i < 16; i++) begin
      rdx(12'h298, {25'h0, sent[i]}, ALL);
    end
    rdx(12'h298, 33'h0, ALL);
    wr(12'h290, 32'h0);
    irq_is(1'b0);
    rdx(12'h294, {1'b0, 32'h1d}, ALL);
    wr(12'h294, 32'h10);
    rdx(12'h290, {1'b0, 32'h10}, ALL);
    rdx(12'h294, {1'b0, 32'h10}, ALL);
    irq_is(1'b1);
    wr(12'h2a0, 32'h1);
    rdx(12'h294, 33'h0, ALL);
    irq_is(1'b0);
    rdx(12'h2a8, {1'b0, 32'h04}, {1'b0, 32'h14});
    wr(12'h29c, 32'hc0);
    brk_q.push_back((13 + 2) * BAUD);
    brk_q.push_back(BAUD);
    wr(12'h29c, 32'hca);
    wr(12'h29c, 32'hc2);
    rdx(12'h29c, {1'b0, 32'hca}, ALL);
    wr(12'h298, 32'h55);
    wr(12'h298, 32'($urandom) & 32'hff); // no wait first
    poll(12'h29c, 32'h08, 32'h00);
    poll(12'h2a8, 32'h14, 32'h04);
    repeat (20 * BAUD) @(posedge pclk);
    wr(12'h2a0, 32'h1);
    wr(12'h294, 32'h0);
    wr(12'h290, 32'h02);
    b = 8'($urandom);
    lufr_lin_node_i.send_byte(b, 1'b0, BAUD);
    repeat (2 * BAUD) @(posedge pclk);
    rdx(12'h294, {1'b0, 32'h02}, ALL);
    irq_is(1'b1);
    rdx(12'h298, {25'h0, b}, ALL);
    wr(12'h294, 32'h02);
    rdx(12'h294, {1'b0, 32'h02}, ALL);
    wr(12'h294, 32'h0);
    rdx(12'h294, 33'h0, ALL);
    irq_is(1'b0);
    chk("break notes", 33'h0, 33'(brk_q.size()));
    final_report();
  end
endmodule : tb_top
